// *** ccsi_defines.svh ***
`ifndef CCSI_DEFINES_SVH
`define CCSI_DEFINES_SVH
// Register word indices on the Avalon side
`define CCSI_REG_CTRL 3'h0
`define CCSI_REG_STATUS 3'h1
`define CCSI_REG_SLOT_BASE 3'h2
`define CCSI_REG_CYCLE 3'h3
`define CCSI_REG_RDATA 3'h4
// Control register fields
`define CCSI_CTRL_START 0
`define CCSI_CTRL_LOCK 1
`define CCSI_CTRL_CNT_LSB 4
// Manual cycle register fields
`define CCSI_CYC_CMD 16
`define CCSI_CYC_READ 17
// Strobe timing, printed in ns, derived in cycles (least times round up)
`define CCSI_CLK_MHZ 200
`define CCSI_E_LOW_NS 40
`define CCSI_E_HIGH_NS 40
`define CCSI_E_LOW_CYC ((`CCSI_E_LOW_NS * `CCSI_CLK_MHZ + 999) / 1000)
`define CCSI_E_HIGH_CYC ((`CCSI_E_HIGH_NS * `CCSI_CLK_MHZ + 999) / 1000)
// Device command words
`define CCSI_OP_ZERO 16'h0000
`define CCSI_OP_ALL_ONES 16'hFFFF
`define CCSI_OP_TCO_DS 16'h0238
`define CCSI_OP_TCO_CT 16'h0200
`define CCSI_OP_TCO_PA 16'h0230
`define CCSI_OP_TCO_SC 16'h0208
`define CCSI_OP_FORCE_FULL 16'h0700
`define CCSI_OP_CTRL_INIT 16'h8040
`define CCSI_OP_SEG_INIT 16'h3808
`define CCSI_OP_SRC_HIT 16'h0005
// Sequence lengths
`define CCSI_PRE_LEN 5
`define CCSI_POST_LEN 7
`endif

// *** ccsi_pkg.sv ***
package ccsi_pkg;
  // One device bus cycle
  typedef struct packed {
    logic cmd;
    logic rd;
    logic [15:0] data;
  } ccsi_cycle_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOW = 4'b0010,
    ST_HIGH = 4'b0100,
    ST_NEXT = 4'b1000
  } ccsi_state_t;
  typedef enum logic [2:0] {
    PH_PRE = 3'b001,
    PH_DEV = 3'b010,
    PH_POST = 3'b100
  } ccsi_phase_t;
endpackage : ccsi_pkg

// *** ccsi_host.sv ***
// Function
// - Host gives every device a distinct slot id, never all ones.
// - Host starts setup with an all-zero command write.
// - Per device the host writes slot target, slot value, then force-full.
// - With all-ones selector one data write loads every comparand.
// - Host writes segment control so writes go to segments one to three.
// - Host writes control for 48 compare bits, 16 RAM bits, no increment.
// - Single device may hold lock request high and use status or local hit.
//
// The Avalon-MM interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ccsi_defines.svh"
module ccsi_host
  import ccsi_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input wire logic clk_in, // 200 MHz clock
  input wire logic srst_in, // Synchronous reset, active high
  input wire logic [2:0] avs_address_in, // Word index
  input wire logic avs_read_in, // Read request
  input wire logic avs_write_in, // Write request
  input wire logic [31:0] avs_writedata_in, // Write data
  output logic [31:0] avs_readdata_out, // Read data
  output logic avs_waitrequest_out, // Stall
  output logic strobe_n_out, // Cycle strobe, active low
  output logic command_vs_data_n_out, // Low for command cycles
  output logic write_n_out, // Low for write cycles
  output logic [15:0] dq_out, // Data to device
  output logic dq_oe_n_out, // Low while host drives dq
  input wire logic [15:0] dq_in, // Data from device
  output logic chain_lock_request_n_out, // Chain lock, active low
  input wire logic full_n_in, // Last device full_out
  input wire logic match_n_in, // Last device match_out
  input wire logic local_hit_n_in // Single-device local_hit_out
);
  localparam logic [7:0] LOW_CYC = 8'(`CCSI_E_LOW_CYC);
  localparam logic [7:0] HIGH_CYC = 8'(`CCSI_E_HIGH_CYC);

  ccsi_state_t state;
  ccsi_phase_t phase;
  ccsi_cycle_t cur;
  ccsi_cycle_t next_cur;
  logic [7:0] tick;
  logic [2:0] step;
  logic [1:0] sub;
  logic [CNT_W-1:0] dev_idx;
  logic [CNT_W-1:0] dev_last;
  logic [15:0] slot_base;
  logic [15:0] slot_id;
  logic lock_en;
  logic init_run;
  logic init_done;
  logic init_err;
  logic manual_pend;
  ccsi_cycle_t manual;
  logic [15:0] rdata;
  logic rd_ack;
  logic [18:0] pin_s1;
  logic [18:0] pin_s2;
  logic wr_ctrl;
  logic wr_cycle;

  // Pin inputs through two flops; only the second stage is read
  always_ff @(posedge clk_in) begin
    pin_s1 <= {local_hit_n_in, match_n_in, full_n_in, dq_in};
    pin_s2 <= pin_s1;
  end

  assign wr_ctrl = avs_write_in && avs_address_in == `CCSI_REG_CTRL;
  assign wr_cycle = avs_write_in && avs_address_in == `CCSI_REG_CYCLE;
  assign slot_id = slot_base + 16'(dev_idx);

  // CTRL and CYCLE writes stall while the engine is busy; reads take one wait cycle
  always_comb begin
    avs_waitrequest_out = 1'b0;
    if (avs_read_in && !rd_ack)
      avs_waitrequest_out = 1'b1;
    if ((wr_cycle || wr_ctrl) && (manual_pend || init_run || state != ST_IDLE))
      avs_waitrequest_out = 1'b1;
  end

  // Read answer registered at the waiting edge; unmapped words read zero
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rd_ack <= 1'b0;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      rd_ack <= avs_read_in && !rd_ack;
      if (avs_read_in && !rd_ack) begin
        unique case (avs_address_in)
          `CCSI_REG_CTRL: avs_readdata_out <= 32'({dev_last, 2'b00, lock_en, 1'b0});
          `CCSI_REG_STATUS: avs_readdata_out <= 32'({!pin_s2[18], !pin_s2[17], !pin_s2[16],
            init_err, init_done, init_run || manual_pend || state != ST_IDLE});
          `CCSI_REG_SLOT_BASE: avs_readdata_out <= 32'(slot_base);
          `CCSI_REG_RDATA: avs_readdata_out <= 32'(rdata);
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Software configuration
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      lock_en <= 1'b0;
      dev_last <= '0;
      slot_base <= 16'h0000;
    end else if (avs_write_in && !avs_waitrequest_out) begin
      if (wr_ctrl) begin
        lock_en <= avs_writedata_in[`CCSI_CTRL_LOCK];
        dev_last <= avs_writedata_in[`CCSI_CTRL_CNT_LSB +: CNT_W];
      end
      if (avs_address_in == `CCSI_REG_SLOT_BASE)
        slot_base <= avs_writedata_in[15:0];
    end
  end

  // Lock held released during setup; single-device use keeps it high
  always_ff @(posedge clk_in) begin
    if (srst_in)
      chain_lock_request_n_out <= 1'b1;
    else
      chain_lock_request_n_out <= !(lock_en && !init_run);
  end

  // Manual single cycle, queued until the strobe engine is free
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      manual_pend <= 1'b0;
      manual <= '0;
    end else if (wr_cycle && !avs_waitrequest_out) begin
      manual_pend <= 1'b1;
      manual.cmd <= avs_writedata_in[`CCSI_CYC_CMD];
      manual.rd <= avs_writedata_in[`CCSI_CYC_READ];
      manual.data <= avs_writedata_in[15:0];
    end else if (state == ST_IDLE && !init_run && manual_pend) begin
      manual_pend <= 1'b0;
    end
  end

  // Setup sequence word for the current step
  always_comb begin
    next_cur = '0;
    next_cur.cmd = 1'b1;
    unique case (phase)
      PH_PRE: begin
        unique case (step)
          3'd0: next_cur.data = `CCSI_OP_ZERO;
          3'd1: next_cur.data = `CCSI_OP_TCO_DS;
          3'd2: next_cur.data = `CCSI_OP_ALL_ONES;
          3'd3: next_cur.data = `CCSI_OP_TCO_CT;
          default: next_cur.data = `CCSI_OP_ZERO; // reset to pass-through
        endcase
      end
      PH_DEV: begin
        unique case (sub)
          2'd0: next_cur.data = `CCSI_OP_TCO_PA;
          2'd1: next_cur.data = slot_id;
          default: next_cur.data = `CCSI_OP_FORCE_FULL;
        endcase
      end
      default: begin
        unique case (step)
          3'd0: next_cur.data = `CCSI_OP_TCO_CT;
          3'd1: next_cur.data = `CCSI_OP_ZERO; // clears forced full
          3'd2: next_cur.data = `CCSI_OP_TCO_CT;
          3'd3: next_cur.data = `CCSI_OP_CTRL_INIT;
          3'd4: next_cur.data = `CCSI_OP_TCO_SC;
          3'd5: next_cur.data = `CCSI_OP_SEG_INIT;
          default: next_cur.data = `CCSI_OP_SRC_HIT; // reads follow top hit
        endcase
      end
    endcase
  end

  // Sequence position and outcome
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      init_run <= 1'b0;
      init_done <= 1'b0;
      init_err <= 1'b0;
      phase <= PH_PRE;
      step <= 3'd0;
      sub <= 2'd0;
      dev_idx <= '0;
    end else if (wr_ctrl && !avs_waitrequest_out && avs_writedata_in[`CCSI_CTRL_START]) begin
      // All-ones id would collide with the global selector
      init_err <= (slot_base + 16'(avs_writedata_in[`CCSI_CTRL_CNT_LSB +: CNT_W])) < slot_base
        || (slot_base + 16'(avs_writedata_in[`CCSI_CTRL_CNT_LSB +: CNT_W])) == `CCSI_OP_ALL_ONES;
      init_run <= !((slot_base + 16'(avs_writedata_in[`CCSI_CTRL_CNT_LSB +: CNT_W])) < slot_base
        || (slot_base + 16'(avs_writedata_in[`CCSI_CTRL_CNT_LSB +: CNT_W])) == `CCSI_OP_ALL_ONES);
      init_done <= 1'b0;
      phase <= PH_PRE;
      step <= 3'd0;
      sub <= 2'd0;
      dev_idx <= '0;
    end else if (init_run && state == ST_NEXT) begin
      unique case (phase)
        PH_PRE: begin
          step <= (step == 3'(`CCSI_PRE_LEN - 1)) ? 3'd0 : step + 3'd1;
          if (step == 3'(`CCSI_PRE_LEN - 1))
            phase <= PH_DEV;
        end
        PH_DEV: begin
          sub <= (sub == 2'd2) ? 2'd0 : sub + 2'd1;
          if (sub == 2'd2) begin
            dev_idx <= dev_idx + 1'b1;
            if (dev_idx == dev_last)
              phase <= PH_POST;
          end
        end
        default: begin
          step <= step + 3'd1;
          if (step == 3'(`CCSI_POST_LEN - 1)) begin
            init_run <= 1'b0;
            init_done <= 1'b1;
          end
        end
      endcase
    end
  end

  // Strobe engine: strobe low phase then recovery high phase
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state <= ST_IDLE;
      tick <= 8'd0;
      cur <= '0;
      rdata <= 16'h0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          tick <= LOW_CYC + 8'd1; // One extra clock so the controls settle before the strobe falls
          if (init_run) begin
            cur <= next_cur;
            state <= ST_LOW;
          end else if (manual_pend) begin
            cur <= manual;
            state <= ST_LOW;
          end
        end
        ST_LOW: begin
          tick <= tick - 8'd1;
          if (tick == 8'd1) begin
            if (cur.rd)
              rdata <= pin_s2[15:0];
            tick <= HIGH_CYC;
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          // High time lets the flag chain ripple
          tick <= tick - 8'd1;
          if (tick == 8'd1)
            state <= ST_NEXT;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Pin drive from flops; strobe trails the controls by one clock since the device latches on its fall
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      strobe_n_out <= 1'b1;
      command_vs_data_n_out <= 1'b1;
      write_n_out <= 1'b1;
      dq_out <= 16'h0000;
      dq_oe_n_out <= 1'b1;
    end else begin
      strobe_n_out <= !(state == ST_LOW && tick <= LOW_CYC);
      command_vs_data_n_out <= !cur.cmd;
      write_n_out <= cur.rd;
      dq_out <= cur.data;
      dq_oe_n_out <= !(state != ST_IDLE && !cur.rd);
    end
  end
endmodule : ccsi_host
`default_nettype wire

// *** ccsi_host_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccsi_host_sva (
  input wire logic clk_in, // Clock
  input wire logic srst_in, // Reset
  input wire logic [2:0] avs_address_in, // Word index
  input wire logic avs_read_in, // Read request
  input wire logic [31:0] avs_readdata_out, // Read data
  input wire logic avs_waitrequest_out, // Stall
  input wire logic strobe_n_out, // Strobe
  input wire logic command_vs_data_n_out, // Command select
  input wire logic write_n_out, // Direction
  input wire logic [15:0] dq_out, // Host data
  input wire logic dq_oe_n_out, // Host drive enable
  input wire logic chain_lock_request_n_out // Lock request
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  logic [15:0] prev_word;
  // Word of the previous device cycle, to judge the value after a slot-target
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prev_word <= 16'h0000;
    end else if ($rose(strobe_n_out)) begin
      prev_word <= dq_out;
    end
  end
  a_strobe_low_len: assert property ($fell(strobe_n_out) |-> !strobe_n_out [*8] ##1 strobe_n_out)
    else $error("strobe low time wrong");
  a_strobe_high_len: assert property ($rose(strobe_n_out) |-> strobe_n_out [*8])
    else $error("strobe high time too short");
  a_cycle_stable: assert property (!strobe_n_out && !$past(strobe_n_out)
    |-> $stable({command_vs_data_n_out, write_n_out, dq_out, dq_oe_n_out}))
    else $error("cycle controls moved mid-cycle");
  a_write_drives: assert property (!strobe_n_out && !write_n_out |-> !dq_oe_n_out)
    else $error("write without bus drive");
  a_read_releases: assert property (!strobe_n_out && write_n_out |-> dq_oe_n_out)
    else $error("host drives bus during read");
  a_read_wait: assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("read answer timing wrong");
  a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out && avs_address_in > 3'h4
    |-> avs_readdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_lock_setup: assert property ($fell(strobe_n_out) && !command_vs_data_n_out && dq_out == 16'h0700
    |-> chain_lock_request_n_out)
    else $error("lock asserted during setup");
  a_id_not_ones: assert property ($fell(strobe_n_out) && !command_vs_data_n_out && prev_word == 16'h0230
    |-> dq_out != 16'hFFFF)
    else $error("slot id all ones");
  c_write_cycle: cover property ($fell(strobe_n_out) && !write_n_out);
  c_read_cycle: cover property ($fell(strobe_n_out) && write_n_out);
  c_force_full: cover property ($fell(strobe_n_out) && dq_out == 16'h0700);
endmodule : ccsi_host_sva
bind ccsi_host ccsi_host_sva ccsi_host_sva_inst (.clk_in(clk_in), .srst_in(srst_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .strobe_n_out(strobe_n_out),
  .command_vs_data_n_out(command_vs_data_n_out), .write_n_out(write_n_out), .dq_out(dq_out),
  .dq_oe_n_out(dq_oe_n_out), .chain_lock_request_n_out(chain_lock_request_n_out));
`default_nettype wire

// *** ccsi_dev_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccsi_dev_model #(
  parameter int N = 2
) (
  input wire logic clk_in, // Paces the idle bus pattern
  input wire logic strobe_n_in, // Cycle strobe
  input wire logic command_vs_data_n_in, // Low for command
  input wire logic write_n_in, // Low for write
  input wire logic chain_lock_request_n_in, // Lock request
  input wire logic [15:0] bus_in, // Resolved data bus
  output logic [15:0] dq_out, // Data driven by the string
  output logic full_n_out, // Last device full flag
  output logic match_n_out, // Last device match flag
  output logic local_hit_n_out // Local hit flag
);
  logic [15:0] slot_id [N];
  logic [N-1:0] forced = '0;
  logic [N:0] full_chain;
  logic [15:0] selector = 16'h0000;
  logic [2:0] target = 3'h0;
  logic pending = 1'h0;
  logic lock_lat = 1'h1;
  logic lock_int = 1'h1;
  logic [1:0] xlate_sel = 2'h0;
  logic [15:0] idle_pat = 16'h5A5A;
  logic [15:0] rd_val;
  logic sel_hit;
  logic [15:0] cmd_log [$];
  int cycles = 0;
  // Full passes down only when every device above is full
  always_comb begin
    full_chain[0] = 1'h1;
    for (int i = 0; i < N; i++) begin
      full_chain[i + 1] = full_chain[i] & forced[i];
    end
  end
  // Reads answered only by the device whose id equals the selector
  always_comb begin
    sel_hit = 1'h0;
    rd_val = 16'h0000;
    for (int i = 0; i < N; i++) begin
      if (selector != 16'hFFFF && slot_id[i] == selector) begin
        sel_hit = 1'h1;
        rd_val = slot_id[i];
      end
    end
  end
  // Idle bus toggles so a stale value is never mistaken for an answer
  always @(posedge clk_in) idle_pat <= ~idle_pat;
  assign dq_out = (!strobe_n_in && write_n_in && sel_hit) ? rd_val : idle_pat;
  assign full_n_out = ~full_chain[N];
  assign match_n_out = 1'h1; // Empty string, no top device
  assign local_hit_n_out = 1'h1;
  // Controls and data are taken on the falling strobe edge
  always @(negedge strobe_n_in) begin
    lock_lat = chain_lock_request_n_in;
    cycles++;
    if (!command_vs_data_n_in && !write_n_in) begin
      cmd_log.push_back(bus_in);
      if (pending) begin
        pending = 1'h0;
        if (target == 3'h6) begin
          for (int i = 0; i < N; i++) if (full_chain[i] && !forced[i]) slot_id[i] = bus_in;
        end else if (target == 3'h7) begin
          selector = bus_in;
        end else if (target == 3'h0) begin
          xlate_sel = bus_in[10:9];
          if (bus_in == 16'h0000) forced = '0;
        end
      end else if (bus_in[15:6] == 10'h008 && bus_in[2:0] == 3'h0) begin
        pending = 1'h1;
        target = bus_in[5:3];
      end else if (bus_in == 16'h0700) begin
        for (int i = 0; i < N; i++) if (full_chain[i] && !forced[i]) forced[i] = 1'h1;
      end
    end
  end
  // Internal lock copy taken on the rising strobe edge; nothing in the model reads it
  always @(posedge strobe_n_in) lock_int = lock_lat;
endmodule : ccsi_dev_model
`default_nettype wire

// *** ccsi_host_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccsi_host_bench;
  logic clk_in, srst_in, av_rd, av_wr, waitreq, strobe_n, cmd_n, write_n, oe_n, lock_n, full_n, match_n, hit_n;
  logic [2:0] av_addr;
  logic [31:0] av_wdata, rdata;
  logic [15:0] host_dq, dev_dq, bus;
  int fails, samples_checked;
  // Shared data line: host wins while it drives, else the string
  assign bus = oe_n ? dev_dq : host_dq;
  ccsi_host #(.CNT_W(4)) ccsi_host_inst (.clk_in(clk_in), .srst_in(srst_in), .avs_address_in(av_addr),
    .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .strobe_n_out(strobe_n), .command_vs_data_n_out(cmd_n),
    .write_n_out(write_n), .dq_out(host_dq), .dq_oe_n_out(oe_n), .dq_in(bus),
    .chain_lock_request_n_out(lock_n), .full_n_in(full_n), .match_n_in(match_n), .local_hit_n_in(hit_n));
  ccsi_dev_model #(.N(2)) dev (.clk_in(clk_in), .strobe_n_in(strobe_n), .command_vs_data_n_in(cmd_n),
    .write_n_in(write_n), .chain_lock_request_n_in(lock_n), .bus_in(bus), .dq_out(dev_dq),
    .full_n_out(full_n), .match_n_out(match_n), .local_hit_n_out(hit_n));
  always #2.5 clk_in = ~clk_in;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  // Bus cycle: hold until waitrequest seen low at an edge, one idle edge after
  task automatic av_xfer(input logic rd, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
    logic w;
    av_addr <= a;
    av_wdata <= d;
    if (rd) av_rd <= 1'h1;
    else av_wr <= 1'h1;
    do begin
      @(posedge clk_in);
      w = waitreq;
      q = rdata;
    end while (w !== 1'h0);
    av_rd <= 1'h0;
    av_wr <= 1'h0;
    @(posedge clk_in);
  endtask : av_xfer
  // Idle after reset, unmapped read returns zero
  task automatic t_reset();
    logic [31:0] d;
    chk(lock_n === 1'h1 && strobe_n === 1'h1, "idle outputs");
    av_xfer(1'h1, 3'h1, 32'h0000_0000, d);
    chk(d[2:0] === 3'h0, "status after reset");
    av_xfer(1'h1, 3'h7, 32'h0000_0000, d);
    chk(d === 32'h0000_0000, "unmapped read");
  endtask : t_reset
  // Two-device setup with lock enabled; a CTRL write stalls until it ends
  task automatic t_init();
    logic [31:0] d;
    av_xfer(1'h0, 3'h2, 32'h0000_0010, d);
    av_xfer(1'h0, 3'h0, 32'h0000_0013, d);
    av_xfer(1'h0, 3'h0, 32'h0000_0000, d);
    av_xfer(1'h1, 3'h1, 32'h0000_0000, d);
    chk(d[2:1] === 2'h1 && d[3] === 1'h0, "setup done, not full");
    chk(dev.cycles == 18 && dev.cmd_log[0] === 16'h0000, "setup length, first word");
    chk(dev.slot_id[0] === 16'h0010 && dev.slot_id[1] === 16'h0011, "slot ids");
    chk(dev.forced === 2'h0 && dev.selector === 16'hFFFF, "flags cleared, global");
    chk(dev.xlate_sel === 2'h0, "pass-through after setup");
    chk(dev.cmd_log[14] === 16'h8040 && dev.cmd_log[16] === 16'h3808, "control values");
  endtask : t_init
  // Last id would reach all ones: refused, nothing sent
  task automatic t_err();
    logic [31:0] d;
    av_xfer(1'h0, 3'h2, 32'h0000_FFFE, d);
    av_xfer(1'h0, 3'h0, 32'h0000_0011, d);
    av_xfer(1'h1, 3'h1, 32'h0000_0000, d);
    chk(d[2] === 1'h1 && dev.cycles == 18, "all-ones id refused");
  endtask : t_err
  // Select device two, read it back through manual cycles
  task automatic t_manual();
    logic [31:0] d;
    av_xfer(1'h0, 3'h3, 32'h0001_0238, d);
    av_xfer(1'h0, 3'h3, 32'h0001_0011, d);
    av_xfer(1'h0, 3'h3, 32'h0002_0000, d);
    av_xfer(1'h0, 3'h0, 32'h0000_0000, d);
    av_xfer(1'h1, 3'h4, 32'h0000_0000, d);
    chk(d[15:0] === 16'h0011 && dev.cycles == 21, "selected device read");
  endtask : t_manual
  // Lock request follows the enable outside setup
  task automatic t_lock();
    logic [31:0] d;
    av_xfer(1'h0, 3'h0, 32'h0000_0002, d);
    @(posedge clk_in);
    chk(lock_n === 1'h0, "lock asserted");
    av_xfer(1'h0, 3'h0, 32'h0000_0000, d);
    @(posedge clk_in);
    chk(lock_n === 1'h1, "lock released");
  endtask : t_lock
  // Main sequence
  initial begin
    {clk_in, av_rd, av_wr, av_addr, av_wdata, fails, samples_checked} = '0;
    srst_in = 1'h1;
    repeat (16) @(posedge clk_in);
    srst_in <= 1'h0;
    @(posedge clk_in);
    t_reset();
    t_init();
    t_err();
    t_manual();
    t_lock();
    give_verdict();
  end
  // Watchdog, far beyond the roughly 450 cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_in);
    fails++;
    give_verdict();
  end
endmodule : ccsi_host_bench
`default_nettype wire
